// [core/drs_defs.vh]
// constants of the duty rotation supervisor
`ifndef DRS_DEFS_VH
`define DRS_DEFS_VH
`define DRS_AXI_AW 4
`define DRS_OFF_CTRL 4'h0
`define DRS_OFF_INTV 4'h4
`define DRS_OFF_STAT 4'h8
`define DRS_OFF_LEFT 4'hC
`define DRS_INTV_DEF 5'h0C
`define DRS_INTV_MIN 5'h01
`define DRS_INTV_MAX 5'h17
`define DRS_SEC_PER_HOUR 17'h00E10
`define DRS_SEC_PER_MIN 17'h0003C
`define DRS_CLK_HZ 40000000
`define DRS_TICK_CYC 26'h2625A00
`define DRS_RESP_OKAY 2'h0
`define DRS_RESP_SLVERR 2'h2
// control register bits
`define DRS_C_ON 0
`define DRS_C_REQ 1
`define DRS_C_VIEWX 2
`define DRS_C_TEMP 3
`endif

// [core/drs_supervisor.v]
// duty rotation supervisor core with axi4-lite register slave
// Function
// - cancelling rotation stops it and commands main and sub units off
// - setting change requests during rotation are refused and raise a notice
// - interval resets to 12 h, accepts only 1 to 23 whole hours
// - interval writable anytime; while counting without error, reloads the counter immediately
// - report each unit link state, on, off or fault with code
// - remaining time blank and reset when off, link fail or fault
// - at zero swap running and backup units and reload counter
// - on link or system error show status view and blink backlight
// - blinking stops when error clears or rotation is cancelled
// - unless left manually, status view returns to operating view after clear
// - rotation off to on: main runs, sub is backup
// - roles alternate at every new rotation cycle
// - running unit link error: keep it, backup on, counter blank
// - backup unit link error: keep both, counter cleared
// - running unit system error: backup on, counter cleared
// - backup unit system error: counter cleared, running unit kept
// - link error clears: running stays, backup off, counter restarts full
// - latched fault needs cancel, unit fault clear command, re-enable
// - after power restore resume with main running and full counter
// - backup switched on or off by temperature difference demand
`include "drs_defs.vh"
module drs_supervisor #(
   parameter TICK_CYC = `DRS_TICK_CYC
) (
   input  wire        clk_i,
   input  wire        reset_n_i,
   input  wire        restore_on_i,
   input  wire [3:0]  s_axi_awaddr_i,
   input  wire        s_axi_awvalid_i,
   output wire        s_axi_awready_o,
   input  wire [31:0] s_axi_wdata_i,
   input  wire [3:0]  s_axi_wstrb_i,
   input  wire        s_axi_wvalid_i,
   output wire        s_axi_wready_o,
   output wire [1:0]  s_axi_bresp_o,
   output wire        s_axi_bvalid_o,
   input  wire        s_axi_bready_i,
   input  wire [3:0]  s_axi_araddr_i,
   input  wire        s_axi_arvalid_i,
   output wire        s_axi_arready_o,
   output wire [31:0] s_axi_rdata_o,
   output wire [1:0]  s_axi_rresp_o,
   output wire        s_axi_rvalid_o,
   input  wire        s_axi_rready_i,
   input  wire        main_link_ok_i,
   input  wire        sub_link_ok_i,
   input  wire        main_on_i,
   input  wire        sub_on_i,
   input  wire        main_fault_i,
   input  wire        sub_fault_i,
   input  wire [7:0]  main_sensor_fault_code_i,
   input  wire [7:0]  sub_sensor_fault_code_i,
   output wire        main_cmd_on_o,
   output wire        sub_cmd_on_o,
   output wire        main_cmd_valid_o,
   output wire        sub_cmd_valid_o,
   output wire        rotation_active_o,
   output wire        settings_locked_o,
   output wire        prohibit_notice_o,
   output wire        status_view_o,
   output wire        backlight_blink_o,
   output wire        time_valid_o,
   output wire [4:0]  hours_o,
   output wire [5:0]  minutes_o,
   output wire [5:0]  seconds_o
);

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   reg        on_reg;
   reg        started_reg;
   reg  [4:0] intv_reg;
   reg        sub_runs_reg;
   reg        main_cmd_reg;
   reg        sub_cmd_reg;
   reg        main_cv_reg;
   reg        sub_cv_reg;
   reg        notice_reg;
   reg        view_reg;
   reg        blink_reg;
   reg        err_d_reg;
   reg [16:0] left_reg;
   reg        run_reg;
   reg [25:0] tick_reg;
   reg        aw_reg;
   reg        w_reg;
   reg [3:0]  awa_reg;
   reg [31:0] wd_reg;
   reg        wd_strb0;
   reg        bv_reg;
   reg [1:0]  br_reg;
   reg        rv_reg;
   reg [31:0] rd_reg;
   reg [1:0]  rr_reg;
   reg        mlink_d_reg;
   reg        slink_d_reg;
   reg        mflt_d_reg;
   reg        sflt_d_reg;

   // full interval in seconds
   function [16:0] hrs_to_sec;
      input [4:0] h;
      begin
         hrs_to_sec = (17'h00000 + {12'h000, h}) * `DRS_SEC_PER_HOUR;
      end
   endfunction

   // ----------------------------------------------------------------
   // axi4-lite handshake
   // ----------------------------------------------------------------
   wire wr_go = aw_reg && w_reg && !bv_reg;
   wire rd_go = s_axi_arvalid_i && !rv_reg;
   assign s_axi_awready_o = !aw_reg && !bv_reg;
   assign s_axi_wready_o  = !w_reg && !bv_reg;
   assign s_axi_arready_o = !rv_reg;
   assign s_axi_bvalid_o  = bv_reg;
   assign s_axi_bresp_o   = br_reg;
   assign s_axi_rvalid_o  = rv_reg;
   assign s_axi_rdata_o   = rd_reg;
   assign s_axi_rresp_o   = rr_reg;

   // register writes act only when byte lane 0 is enabled
   wire wr_ctrl = wr_go && (awa_reg == `DRS_OFF_CTRL) && wd_strb0;
   wire wr_intv = wr_go && (awa_reg == `DRS_OFF_INTV) && wd_strb0;
   wire wr_map  = (awa_reg == `DRS_OFF_CTRL) || (awa_reg == `DRS_OFF_INTV);
   wire [4:0] new_intv = wd_reg[4:0];
   wire intv_ok = (new_intv >= `DRS_INTV_MIN) && (new_intv <= `DRS_INTV_MAX);

   // ----------------------------------------------------------------
   // error conditions
   // ----------------------------------------------------------------
   wire link_err  = !main_link_ok_i || !sub_link_ok_i;
   wire sys_err   = main_fault_i || sub_fault_i;
   wire any_err   = on_reg && (link_err || sys_err);
   wire run_link  = sub_runs_reg ? sub_link_ok_i : main_link_ok_i;
   wire bak_link  = sub_runs_reg ? main_link_ok_i : sub_link_ok_i;
   wire run_fl    = sub_runs_reg ? sub_fault_i : main_fault_i;
   wire link_fall = sub_runs_reg ? (slink_d_reg && !sub_link_ok_i)
                                 : (mlink_d_reg && !main_link_ok_i);
   wire flt_rise  = sub_runs_reg ? (!sflt_d_reg && sub_fault_i)
                                 : (!mflt_d_reg && main_fault_i);
   wire link_rise = (!mlink_d_reg && main_link_ok_i) || (!slink_d_reg && sub_link_ok_i);
   // a latched unit fault is only left behind by a cancel and a fresh enable
   wire cancel    = wr_ctrl && !wd_reg[`DRS_C_ON] && on_reg;
   wire enable    = wr_ctrl && wd_reg[`DRS_C_ON] && !on_reg;
   wire start     = enable || (started_reg && restore_on_i);
   wire expire    = run_reg && !any_err && (left_reg == 17'h00000);
   wire sec_tick  = (tick_reg == 26'h0000000);
   wire [16:0] full = hrs_to_sec(intv_reg);

   // ----------------------------------------------------------------
   // bus channel registers
   // ----------------------------------------------------------------
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         aw_reg   <= 1'b0;
         w_reg    <= 1'b0;
         awa_reg  <= 4'h0;
         wd_reg   <= 32'h00000000;
         wd_strb0 <= 1'b0;
         bv_reg   <= 1'b0;
         br_reg   <= `DRS_RESP_OKAY;
         rv_reg   <= 1'b0;
         rd_reg   <= 32'h00000000;
         rr_reg   <= `DRS_RESP_OKAY;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_reg  <= 1'b1;
            awa_reg <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_reg    <= 1'b1;
            wd_reg   <= s_axi_wdata_i;
            wd_strb0 <= s_axi_wstrb_i[0];
         end
         // response once address and data are both held
         if (wr_go) begin
            aw_reg <= 1'b0;
            w_reg  <= 1'b0;
            bv_reg <= 1'b1;
            br_reg <= wr_map ? `DRS_RESP_OKAY : `DRS_RESP_SLVERR;
         end else if (bv_reg && s_axi_bready_i) begin
            bv_reg <= 1'b0;
         end
         // read data captured at the address handshake
         if (rd_go) begin
            rv_reg <= 1'b1;
            rr_reg <= `DRS_RESP_OKAY;
            case (s_axi_araddr_i)
               `DRS_OFF_CTRL: rd_reg <= {29'h0, view_reg, notice_reg, on_reg};
               `DRS_OFF_INTV: rd_reg <= {27'h0, intv_reg};
               `DRS_OFF_STAT: rd_reg <= {8'h00, sub_sensor_fault_code_i,
                  main_sensor_fault_code_i, blink_reg, sub_runs_reg,
                  sub_fault_i, sub_on_i, sub_link_ok_i,
                  main_fault_i, main_on_i, main_link_ok_i};
               `DRS_OFF_LEFT: rd_reg <= {14'h0, time_valid_o, left_reg};
               default: begin
                  rd_reg <= 32'h00000000;
                  rr_reg <= `DRS_RESP_SLVERR;
               end
            endcase
         end else if (rv_reg && s_axi_rready_i) begin
            rv_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // rotation control
   // ----------------------------------------------------------------
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         on_reg       <= 1'b0;
         started_reg  <= 1'b1;
         intv_reg     <= `DRS_INTV_DEF;
         sub_runs_reg <= 1'b0;
         main_cmd_reg <= 1'b0;
         sub_cmd_reg  <= 1'b0;
         main_cv_reg  <= 1'b0;
         sub_cv_reg   <= 1'b0;
         notice_reg   <= 1'b0;
         left_reg     <= 17'h00000;
         run_reg      <= 1'b0;
         tick_reg     <= 26'h0000000;
         mlink_d_reg  <= 1'b1;
         slink_d_reg  <= 1'b1;
         mflt_d_reg   <= 1'b0;
         sflt_d_reg   <= 1'b0;
      end else begin
         // edge detectors of link and fault inputs
         mlink_d_reg <= main_link_ok_i;
         slink_d_reg <= sub_link_ok_i;
         mflt_d_reg  <= main_fault_i;
         sflt_d_reg  <= sub_fault_i;
         main_cv_reg <= 1'b0;
         sub_cv_reg  <= 1'b0;
         started_reg <= 1'b0;
         // one-second prescaler
         tick_reg <= (sec_tick || !run_reg) ? TICK_CYC[25:0] - 26'h0000001
                                             : tick_reg - 26'h0000001;
         // refused setting change raises notice, cleared by software
         if (wr_ctrl && wd_reg[`DRS_C_REQ] && on_reg)
            notice_reg <= 1'b1;
         else if (wr_ctrl && !wd_reg[`DRS_C_REQ])
            notice_reg <= 1'b0;
         if (wr_intv && intv_ok)
            intv_reg <= new_intv;
         if (cancel) begin
            on_reg       <= 1'b0;
            run_reg      <= 1'b0;
            left_reg     <= 17'h00000;
            main_cmd_reg <= 1'b0;
            sub_cmd_reg  <= 1'b0;
            main_cv_reg  <= 1'b1;
            sub_cv_reg   <= 1'b1;
         end else if (start) begin
            on_reg       <= 1'b1;
            sub_runs_reg <= 1'b0;
            run_reg      <= 1'b1;
            left_reg     <= full;
            main_cmd_reg <= 1'b1;
            sub_cmd_reg  <= 1'b0;
            main_cv_reg  <= 1'b1;
            sub_cv_reg   <= 1'b1;
         end else if (on_reg) begin
            if (sys_err || link_err) begin
               run_reg  <= 1'b0;
               left_reg <= 17'h00000;
               if ((link_fall && bak_link) || (flt_rise && !run_link) ||
                   (flt_rise && run_fl)) begin
                  // running unit lost: bring backup on
                  if (sub_runs_reg) begin
                     main_cmd_reg <= 1'b1;
                     main_cv_reg  <= 1'b1;
                  end else begin
                     sub_cmd_reg <= 1'b1;
                     sub_cv_reg  <= 1'b1;
                  end
               end
            end else if (!run_reg && link_rise) begin
               run_reg  <= 1'b1;
               left_reg <= full;
               if (sub_runs_reg) begin
                  main_cmd_reg <= 1'b0;
                  main_cv_reg  <= 1'b1;
               end else begin
                  sub_cmd_reg <= 1'b0;
                  sub_cv_reg  <= 1'b1;
               end
            end else if (expire) begin
               sub_runs_reg <= !sub_runs_reg;
               left_reg     <= full;
               main_cmd_reg <= sub_runs_reg;
               sub_cmd_reg  <= !sub_runs_reg;
               main_cv_reg  <= 1'b1;
               sub_cv_reg   <= 1'b1;
            end else if (run_reg && sec_tick) begin
               left_reg <= left_reg - 17'h00001;
            end
            // demand from temperature difference drives backup unit;
            // an expiry in the same cycle wins so the new running unit stays on
            if (wr_ctrl && run_reg && !sys_err && !link_err && !expire) begin
               if (sub_runs_reg) begin
                  main_cmd_reg <= wd_reg[`DRS_C_TEMP];
                  main_cv_reg  <= 1'b1;
               end else begin
                  sub_cmd_reg <= wd_reg[`DRS_C_TEMP];
                  sub_cv_reg  <= 1'b1;
               end
            end
         end
         // a confirmed interval while counting reloads the counter; placed
         // last so a second tick or an expiry in the same cycle cannot undo it
         if (wr_intv && intv_ok && on_reg && run_reg && !sys_err && !link_err)
            left_reg <= hrs_to_sec(new_intv);
      end
   end

   // ----------------------------------------------------------------
   // status view and backlight
   // ----------------------------------------------------------------
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         view_reg  <= 1'b0;
         blink_reg <= 1'b0;
         err_d_reg <= 1'b0;
      end else begin
         err_d_reg <= any_err;
         if (any_err && !err_d_reg) begin
            view_reg  <= 1'b1;
            blink_reg <= 1'b1;
         end else if (!any_err) begin
            blink_reg <= 1'b0;
            if (err_d_reg)
               view_reg <= 1'b0;
         end
         // a new error in the same cycle wins over a manual exit
         if (wr_ctrl && wd_reg[`DRS_C_VIEWX] && !(any_err && !err_d_reg))
            view_reg <= 1'b0; // manual exit
      end
   end

   // ----------------------------------------------------------------
   // outputs and time split
   // ----------------------------------------------------------------
   wire [16:0] hr_part = left_reg / `DRS_SEC_PER_HOUR;
   wire [16:0] rem_h   = left_reg - hr_part * `DRS_SEC_PER_HOUR;
   wire [16:0] mn_part = rem_h / `DRS_SEC_PER_MIN;
   wire [16:0] sc_part = rem_h - mn_part * `DRS_SEC_PER_MIN;
   assign time_valid_o      = on_reg && run_reg && !link_err && !sys_err;
   assign hours_o           = time_valid_o ? hr_part[4:0] : 5'h00;
   assign minutes_o         = time_valid_o ? mn_part[5:0] : 6'h00;
   assign seconds_o         = time_valid_o ? sc_part[5:0] : 6'h00;
   assign main_cmd_on_o     = main_cmd_reg;
   assign sub_cmd_on_o      = sub_cmd_reg;
   assign main_cmd_valid_o  = main_cv_reg;
   assign sub_cmd_valid_o   = sub_cv_reg;
   assign rotation_active_o = on_reg;
   assign settings_locked_o = on_reg;
   assign prohibit_notice_o = notice_reg;
   assign status_view_o     = view_reg;
   assign backlight_blink_o = blink_reg;

endmodule // drs_supervisor

// [sim/drs_unit_model.sv]
// behavioural model of one indoor unit behind its control link
module drs_unit_model #(
   parameter logic [7:0]  FAULT_CODE = 8'h5A,   // arbitrary code value
   parameter logic [15:0] OPEN_CYC   = 16'h01E0, // link silence before settings reopen
   parameter logic [15:0] OFF_CYC    = 16'h02D0  // link silence before the unit stops
) (
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       cmd_on_i,
   input  wire logic       cmd_valid_i,
   input  wire logic       link_break_i,
   input  wire logic       fault_inject_i,
   input  wire logic       fault_clear_i,
   output wire logic       link_ok_o,
   output logic            on_o,
   output logic            fault_o,
   output wire logic [7:0] code_o
);
   timeunit 1ns;
   timeprecision 1ps;
   assign link_ok_o = !link_break_i;
   assign code_o = fault_o ? FAULT_CODE : 8'h00;
   // link silence timer: settings reopen first, later the unit stops
   logic [15:0] quiet;
   logic        settings_open;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         quiet <= 16'h0000;
         settings_open <= 1'b0;
      end else begin
         if (!link_break_i) quiet <= 16'h0000;
         else if (quiet != OFF_CYC) quiet <= quiet + 16'h0001;
         settings_open <= link_break_i && (quiet >= OPEN_CYC);
      end
   end
   // fault latches and switches the unit off until a fault clear command
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         on_o <= 1'b0;
         fault_o <= 1'b0;
      end else if (fault_inject_i) begin
         fault_o <= 1'b1;
         on_o <= 1'b0;
      end else if (fault_clear_i) begin
         fault_o <= 1'b0;
      end else if (quiet == OFF_CYC) begin
         on_o <= 1'b0;
      end else if (cmd_valid_i && !link_break_i && !fault_o) begin
         on_o <= cmd_on_i;
      end
   end
endmodule // drs_unit_model

// [sim/drs_supervisor_sva.sv]
// assertion checker of the duty rotation supervisor ports
module drs_supervisor_sva #(
   parameter TICK_CYC = 4
) (
   input wire logic       clk_i,
   input wire logic       reset_n_i,
   input wire logic       main_link_ok_i,
   input wire logic       sub_link_ok_i,
   input wire logic       main_fault_i,
   input wire logic       sub_fault_i,
   input wire logic       main_cmd_on_o,
   input wire logic       sub_cmd_on_o,
   input wire logic       main_cmd_valid_o,
   input wire logic       s_axi_bvalid_o,
   input wire logic       rotation_active_o,
   input wire logic       settings_locked_o,
   input wire logic       status_view_o,
   input wire logic       backlight_blink_o,
   input wire logic       time_valid_o,
   input wire logic [4:0] hours_o,
   input wire logic [5:0] minutes_o,
   input wire logic [5:0] seconds_o
);
   // remaining time folded back into seconds
   logic [16:0] tot;
   assign tot = hours_o * 17'h00E10 + minutes_o * 17'h0003C + seconds_o;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   property p_lock; settings_locked_o == rotation_active_o; endproperty
   a_lock: assert property (p_lock) else $error("lock differs from rotation");
   property p_off_blank; !rotation_active_o |-> !time_valid_o; endproperty
   a_off_blank: assert property (p_off_blank) else $error("time shown while off");
   property p_blank_zero; !time_valid_o |-> tot == 17'h00000; endproperty
   a_blank_zero: assert property (p_blank_zero) else $error("blank time not zero");
   property p_err_blank;
      (rotation_active_o && (!main_link_ok_i || !sub_link_ok_i || main_fault_i || sub_fault_i))
         [*3] |-> !time_valid_o;
   endproperty
   a_err_blank: assert property (p_err_blank) else $error("time shown on error");
   property p_tick;
      time_valid_o && $past(time_valid_o) && !s_axi_bvalid_o && tot < $past(tot)
         |-> tot == $past(tot) - 17'h00001;
   endproperty
   a_tick: assert property (p_tick) else $error("count skipped a second");
   property p_start; $rose(rotation_active_o) |-> ##[0:2] (main_cmd_on_o && !sub_cmd_on_o);
   endproperty
   a_start: assert property (p_start) else $error("start roles wrong");
   property p_cancel;
      $fell(rotation_active_o) |-> ##[0:2] (!main_cmd_on_o && !sub_cmd_on_o && !backlight_blink_o);
   endproperty
   a_cancel: assert property (p_cancel) else $error("cancel left units on");
   property p_run_link;
      rotation_active_o && sub_cmd_on_o && !main_cmd_on_o && $fell(sub_link_ok_i)
         |-> ##[1:4] (main_cmd_on_o && sub_cmd_on_o);
   endproperty
   a_run_link: assert property (p_run_link) else $error("backup not started");
   property p_swap; rotation_active_o && time_valid_o && tot == 17'h00000 |-> ##[1:3] main_cmd_valid_o;
   endproperty
   a_swap: assert property (p_swap) else $error("no command at expiry");
   property p_alarm;
      rotation_active_o && $fell(sub_link_ok_i) |-> ##[1:3] (backlight_blink_o && status_view_o);
   endproperty
   a_alarm: assert property (p_alarm) else $error("no alarm on link loss");
   c_start: cover property ($rose(rotation_active_o));
   c_swap: cover property ($rose(sub_cmd_on_o) && !main_cmd_on_o);
   c_blink: cover property ($rose(backlight_blink_o));
endmodule // drs_supervisor_sva
bind drs_supervisor drs_supervisor_sva #(.TICK_CYC(TICK_CYC)) u_drs_supervisor_sva (
   .clk_i, .reset_n_i, .main_link_ok_i, .sub_link_ok_i, .main_fault_i, .sub_fault_i,
   .main_cmd_on_o, .sub_cmd_on_o, .main_cmd_valid_o, .s_axi_bvalid_o,
   .rotation_active_o, .settings_locked_o,
   .status_view_o, .backlight_blink_o, .time_valid_o, .hours_o, .minutes_o, .seconds_o);

// [sim/drs_supervisor_test.sv]
// self-checking bench of the duty rotation supervisor
`include "drs_defs.vh"
module drs_supervisor_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 1'b0, reset_n_i = 1'b0, restore_on_i = 1'b0;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0, rd, seed = 32'h3650;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        m_brk = 1'b0, s_brk = 1'b0, m_flt = 1'b0, s_flt = 1'b0, m_clr = 1'b0, s_clr = 1'b0;
   wire         awready, wready, bvalid, arready, rvalid, m_ok, s_ok, m_on, s_on, m_err, s_err;
   wire         m_cmd, s_cmd, m_cv, s_cv, notice, view, blink, tv;
   wire [1:0]   bresp, rresp;
   wire [31:0]  rdata;
   wire [7:0]   m_code, s_code;
   int          n_fail = 0, checks_done = 0, cyc = 0;
   logic [4:0]  iv, v;
   logic [4:0]  tbl [4] = '{5'h00, 5'h01, 5'h17, 5'h18};
   drs_supervisor #(.TICK_CYC(4)) u_drs_supervisor (.clk_i, .reset_n_i, .restore_on_i,
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
      .main_link_ok_i(m_ok), .sub_link_ok_i(s_ok), .main_on_i(m_on), .sub_on_i(s_on),
      .main_fault_i(m_err), .sub_fault_i(s_err), .main_sensor_fault_code_i(m_code),
      .sub_sensor_fault_code_i(s_code), .main_cmd_on_o(m_cmd), .sub_cmd_on_o(s_cmd),
      .main_cmd_valid_o(m_cv), .sub_cmd_valid_o(s_cv), .rotation_active_o(), .settings_locked_o(),
      .prohibit_notice_o(notice), .status_view_o(view), .backlight_blink_o(blink),
      .time_valid_o(tv), .hours_o(), .minutes_o(), .seconds_o());
   drs_unit_model #(.FAULT_CODE(8'h5A)) u_main (.clk_i, .reset_n_i, .cmd_on_i(m_cmd),
      .cmd_valid_i(m_cv), .link_break_i(m_brk), .fault_inject_i(m_flt), .fault_clear_i(m_clr),
      .link_ok_o(m_ok), .on_o(m_on), .fault_o(m_err), .code_o(m_code));
   drs_unit_model #(.FAULT_CODE(8'hA6)) u_sub (.clk_i, .reset_n_i, .cmd_on_i(s_cmd),
      .cmd_valid_i(s_cv), .link_break_i(s_brk), .fault_inject_i(s_flt), .fault_clear_i(s_clr),
      .link_ok_o(s_ok), .on_o(s_on), .fault_o(s_err), .code_o(s_code));
   always #12.5 clk_i = ~clk_i;
   // cut a hang short
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [4:0] exp_intv(input logic [4:0] p, input logic [4:0] n);
      return (n >= `DRS_INTV_MIN && n <= `DRS_INTV_MAX) ? n : p;
   endfunction
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %s got %h want %h", $time, w, got, exp);
      end
   endtask
   task automatic chk_rng(input logic [31:0] got, input int lo, input int hi, input string w);
      checks_done++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         n_fail++;
         $display("unexpected at %0t: %s got %0d", $time, w, got);
      end
   endtask
   // write and read bus cycles, each channel held until taken
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk_i);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [3:0] a);
      @(posedge clk_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk_i);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rready <= 1'b0;
   endtask
   task automatic rdm(input logic [3:0] a, input logic [31:0] m, e, input string w);
      axi_rd(a);
      chk(rd & m, e, w);
   endtask
   task automatic left(input int lo, input int hi, input string w);
      axi_rd(`DRS_OFF_LEFT);
      chk_rng({15'h0, rd[16:0]}, lo, hi, w);
   endtask
   task automatic units(input logic em, input logic es, input string w);
      repeat (8) @(posedge clk_i);
      chk({30'h0, m_on, s_on}, {30'h0, em, es}, w);
   endtask
   task automatic flags(input logic [2:0] e, input string w);
      chk({29'h0, tv, blink, view}, {29'h0, e}, w);
   endtask
   task automatic stat();
      axi_rd(`DRS_OFF_STAT);
      chk({8'h0, rd[23:8], 2'b00, rd[5:0]},
          {8'h0, s_code, m_code, 2'b00, s_err, s_on, s_ok, m_err, m_on, m_ok}, "stat");
   endtask
   // main sequence
   initial begin
      repeat (5) @(posedge clk_i);
      reset_n_i <= 1'b1;
      iv = `DRS_INTV_DEF;
      rdm(`DRS_OFF_INTV, 32'h1F, 32'h0C, "intv reset");
      for (int i = 0; i < 8; i++) begin
         v = (i < 4) ? tbl[i] : 5'(xs());
         axi_wr(`DRS_OFF_INTV, {27'h0, v});
         iv = exp_intv(iv, v);
         rdm(`DRS_OFF_INTV, 32'h1F, {27'h0, iv}, "intv");
      end
      axi_wr(`DRS_OFF_INTV, 32'h1);
      axi_wr(`DRS_OFF_CTRL, 32'h1);
      units(1'b1, 1'b0, "start");
      left(3590, 3600, "left full");
      axi_wr(`DRS_OFF_CTRL, 32'h3);
      rdm(`DRS_OFF_CTRL, 32'h2, 32'h2, "notice");
      chk({31'h0, notice}, 32'h1, "notice pin");
      axi_wr(`DRS_OFF_CTRL, 32'h9);
      units(1'b1, 1'b1, "demand");
      axi_wr(`DRS_OFF_CTRL, 32'h1);
      units(1'b1, 1'b0, "demand off");
      for (int n = 0; n < 16000 && s_on !== 1'b1; n++) @(posedge clk_i);
      units(1'b0, 1'b1, "swap");
      left(3590, 3600, "reload");
      axi_wr(`DRS_OFF_INTV, 32'h2);
      left(7190, 7200, "intv reload");
      s_brk <= 1'b1;
      units(1'b1, 1'b1, "run link lost");
      flags(3'b011, "alarm");
      stat();
      s_brk <= 1'b0;
      units(1'b0, 1'b1, "link back");
      flags(3'b100, "alarm gone");
      left(7190, 7200, "restart");
      m_brk <= 1'b1;
      units(1'b0, 1'b1, "backup link lost");
      flags(3'b011, "backup alarm");
      axi_wr(`DRS_OFF_CTRL, 32'h5);
      flags(3'b010, "manual exit");
      m_brk <= 1'b0;
      units(1'b0, 1'b1, "backup link back");
      m_flt <= 1'b1;
      @(posedge clk_i);
      m_flt <= 1'b0;
      units(1'b0, 1'b1, "backup fault");
      flags(3'b011, "fault alarm");
      axi_wr(`DRS_OFF_CTRL, 32'h0);
      units(1'b0, 1'b0, "cancel");
      chk({31'h0, blink}, 32'h0, "blink stop");
      m_clr <= 1'b1;
      @(posedge clk_i);
      m_clr <= 1'b0;
      axi_wr(`DRS_OFF_CTRL, 32'h1);
      units(1'b1, 1'b0, "re-enable");
      m_flt <= 1'b1;
      @(posedge clk_i);
      m_flt <= 1'b0;
      units(1'b0, 1'b1, "run fault");
      s_flt <= 1'b1;
      @(posedge clk_i);
      s_flt <= 1'b0;
      units(1'b0, 1'b0, "both faulted");
      stat();
      axi_wr(`DRS_OFF_CTRL, 32'h0);
      m_clr <= 1'b1;
      s_clr <= 1'b1;
      @(posedge clk_i);
      m_clr <= 1'b0;
      s_clr <= 1'b0;
      restore_on_i <= 1'b1;
      reset_n_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      reset_n_i <= 1'b1;
      units(1'b1, 1'b0, "restore");
      left(43190, 43200, "restore full");
      tally_and_finish();
   end
endmodule // drs_supervisor_test
